/* File: include/asc_pkg.sv */
// Constants for the converter start and trigger control block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package asc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ASC_ADR_W = 4;
   localparam logic [ASC_ADR_W-1:0] ASC_OFS_STATUS = 4'h0;
   localparam logic [ASC_ADR_W-1:0] ASC_OFS_RESULT = 4'h4;
   localparam logic [ASC_ADR_W-1:0] ASC_OFS_CTL = 4'h8;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int ASC_BIT_REG_GO = 22;
   localparam int ASC_BIT_INJ_GO = 21;
   localparam int ASC_BIT_REG_EXT_EN = 20;
   localparam int ASC_POS_REG_SRC = 17;
   localparam int ASC_BIT_INJ_EXT_EN = 15;
   localparam int ASC_POS_INJ_SRC = 12;
   localparam int ASC_BIT_ALIGN = 11;
   localparam int ASC_BIT_DMA = 8;
   localparam int ASC_BIT_REPEAT = 1;
   localparam int ASC_BIT_POWER = 0;
   localparam logic [31:0] ASC_CTL_WMASK = 32'h007ef903;
   localparam logic [31:0] ASC_CTL_RESET = 32'h00000000;
   localparam logic [2:0] ASC_SRC_SOFT = 3'h7;

   // ----------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------
   localparam int ASC_ST_POWER = 0;
   localparam int ASC_ST_BUSY_REG = 1;
   localparam int ASC_ST_BUSY_INJ = 2;
   localparam int ASC_ST_VALID = 3;

   // ----------------------------------------------------------------
   // Conversion data
   // ----------------------------------------------------------------
   localparam int ASC_RAW_W = 12;
   localparam int ASC_RES_W = 16;

endpackage

/* File: rtl/asc_trig_sel.sv */
// One-of-eight trigger event selector for a conversion group.
// Assumes every event input except index 7, the soft start bit held until its conversion begins, is a one-cycle pulse on the block clock.
`timescale 1ns/100ps
module asc_trig_sel (
   // Candidate events, index equals the source code
   input wire logic [7:0] event_in,
   // Source code
   input wire logic [2:0] source_in,
   // Selected event
   output logic hit_out
);
   import asc_pkg::*;

   always_comb begin
      hit_out = event_in[source_in];
   end

endmodule

/* File: rtl/asc_ctrl.sv */
// Start, trigger and power control of a converter, with its control register.
// Assumes a classic Wishbone master, a converter core that pulses done with data,
// and trigger sources that give one-cycle pulses on clk_in.
`timescale 1ns/100ps

// Contract
// RQ1 - Hardware clears regular soft start when conversion begins
// RQ2 - Injected soft start: set, hardware or software clears
// RQ3 - Regular external enable gates regular external starts
// RQ4 - Regular source code selects one of eight events
// RQ5 - Injected external enable gates injected external starts
// RQ6 - Injected source code selects one of eight events
// RQ7 - Justification bit: one left, zero right
// RQ8 - Injected results always right justified
// RQ9 - DMA bit gates memory requests per result
// RQ10 - Repeat bit restarts conversions back to back
// RQ11 - Power set from zero only wakes converter
// RQ12 - Power set again starts a conversion
// RQ13 - Power cleared stops activity, powers down
// RQ14 - Power restart only when nothing else changes
// RQ15 - Follow-regular mode needs injected external trigger off; no follow-regular mode is implemented
// RQ16 - One trigger pulse starts at most one conversion
// RQ17 - Fields reset zero, reserved bits read zero
module asc_ctrl (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [asc_pkg::ASC_ADR_W-1:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // Regular group trigger events
   input wire logic tim1_timer_trigger_out_in,
   input wire logic tim1_cc1_in,
   input wire logic tim1_cc2_in,
   input wire logic tim2_timer_trigger_out_in,
   input wire logic tim2_cc1_in,
   input wire logic tim3_cc1_in,
   input wire logic external_line11_in,
   // Injected group trigger events
   input wire logic tim1_cc3_in,
   input wire logic tim1_cc4_in,
   input wire logic tim2_cc3_in,
   input wire logic tim2_cc4_in,
   input wire logic tim2_cc2_in,
   input wire logic tim3_cc2_in,
   input wire logic external_line15_in,
   // Converter core
   input wire logic core_done_in,
   input wire logic [asc_pkg::ASC_RAW_W-1:0] core_raw_in,
   output logic core_power_out,
   output logic reg_start_out,
   output logic inj_start_out,
   // Results and memory requests
   output logic [asc_pkg::ASC_RES_W-1:0] result_out,
   output logic result_valid_out,
   output logic dma_req_out
);
   import asc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic soft_go;
      logic inj_go;
      logic reg_ext_en;
      logic [2:0] reg_src;
      logic inj_ext_en;
      logic [2:0] inj_src;
      logic align;
      logic dma_en;
      logic repeat_on;
      logic power;
      logic busy_reg;
      logic busy_inj;
      logic reg_start;
      logic inj_start;
      logic [ASC_RES_W-1:0] result;
      logic result_valid;
      logic dma_req;
   } asc_state_t;

   asc_state_t s;
   asc_state_t next_s;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] byte_mask(input logic [3:0] sel);
      byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   function automatic logic [31:0] ctl_word(input asc_state_t st);
      logic [31:0] w;
      w = 32'h00000000;
      w[ASC_BIT_REG_GO] = st.soft_go;
      w[ASC_BIT_INJ_GO] = st.inj_go;
      w[ASC_BIT_REG_EXT_EN] = st.reg_ext_en;
      w[ASC_POS_REG_SRC +: 3] = st.reg_src;
      w[ASC_BIT_INJ_EXT_EN] = st.inj_ext_en;
      w[ASC_POS_INJ_SRC +: 3] = st.inj_src;
      w[ASC_BIT_ALIGN] = st.align;
      w[ASC_BIT_DMA] = st.dma_en;
      w[ASC_BIT_REPEAT] = st.repeat_on;
      w[ASC_BIT_POWER] = st.power;
      ctl_word = w;
   endfunction

   // ----------------------------------------------------------------
   // Trigger selection
   // ----------------------------------------------------------------
   logic reg_hit;
   logic inj_hit;

   asc_trig_sel u_reg_sel (
      .event_in ({s.soft_go, external_line11_in, tim3_cc1_in, tim2_cc1_in,
                  tim2_timer_trigger_out_in, tim1_cc2_in, tim1_cc1_in,
                  tim1_timer_trigger_out_in}),
      .source_in (s.reg_src),
      .hit_out (reg_hit)
   ); // RQ4

   asc_trig_sel u_inj_sel (
      .event_in ({s.inj_go, external_line15_in, tim3_cc2_in, tim2_cc2_in,
                  tim2_cc4_in, tim2_cc3_in, tim1_cc4_in, tim1_cc3_in}),
      .source_in (s.inj_src),
      .hit_out (inj_hit)
   ); // RQ6

   // ----------------------------------------------------------------
   // Bus decode and start arbitration
   // ----------------------------------------------------------------
   logic [31:0] bm;
   logic [31:0] ctl_now;
   logic [31:0] merged;
   logic bus_req;
   logic wr_ctl;
   logic rd_res;
   logic kick;
   logic reg_trig;
   logic inj_trig;
   logic idle;
   logic fire_reg;
   logic fire_inj;

   always_comb begin
      bm = byte_mask(wb_sel_in);
      ctl_now = ctl_word(s);
      merged = (ctl_now & ~bm) | (wb_dat_in & bm & ASC_CTL_WMASK);
      bus_req = wb_cyc_in & wb_stb_in;
      // A write lands on the edge at which the master sees ack high.
      wr_ctl = bus_req & wb_we_in & s.ack & (wb_adr_in == ASC_OFS_CTL);
      rd_res = bus_req & ~wb_we_in & s.ack & (wb_adr_in == ASC_OFS_RESULT);
      kick = wr_ctl & s.power & merged[ASC_BIT_POWER]
         & (((merged ^ ctl_now) & ASC_CTL_WMASK & ~32'h00000001) == 32'h00000000); // RQ12 RQ14
      reg_trig = s.reg_ext_en & reg_hit; // RQ3
      inj_trig = s.inj_ext_en & inj_hit; // RQ5
      // A trigger pulse that meets a busy or sleeping converter is dropped.
      idle = s.power & ~s.busy_reg & ~s.busy_inj; // RQ16
      fire_inj = idle & inj_trig;
      fire_reg = idle & ~inj_trig & (reg_trig | kick);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.reg_start = 1'b0;
      next_s.inj_start = 1'b0;
      next_s.dma_req = 1'b0;
      next_s.ack = bus_req & ~s.ack;
      if (bus_req & ~s.ack) begin
         unique case (wb_adr_in)
            ASC_OFS_CTL: next_s.rdata = ctl_now; // RQ17
            ASC_OFS_STATUS: begin
               next_s.rdata = 32'h00000000;
               next_s.rdata[ASC_ST_POWER] = s.power;
               next_s.rdata[ASC_ST_BUSY_REG] = s.busy_reg;
               next_s.rdata[ASC_ST_BUSY_INJ] = s.busy_inj;
               next_s.rdata[ASC_ST_VALID] = s.result_valid;
            end
            ASC_OFS_RESULT: next_s.rdata = {16'h0000, s.result};
            default: next_s.rdata = 32'h00000000;
         endcase
      end

      if (rd_res) begin
         next_s.result_valid = 1'b0;
      end

      if (fire_inj) begin
         next_s.inj_start = 1'b1;
         next_s.busy_inj = 1'b1;
         next_s.inj_go = 1'b0; // RQ2
      end
      if (fire_reg) begin
         next_s.reg_start = 1'b1;
         next_s.busy_reg = 1'b1;
         next_s.soft_go = 1'b0; // RQ1
      end

      if (core_done_in & s.busy_reg) begin
         next_s.result = s.align ? {core_raw_in, 4'h0} : {4'h0, core_raw_in}; // RQ7
         next_s.result_valid = 1'b1;
         next_s.dma_req = s.dma_en; // RQ9
         if (s.repeat_on) begin
            next_s.reg_start = 1'b1; // RQ10
            next_s.soft_go = 1'b0;
         end else begin
            next_s.busy_reg = 1'b0;
         end
      end
      if (core_done_in & s.busy_inj) begin
         next_s.result = {4'h0, core_raw_in}; // RQ8
         next_s.result_valid = 1'b1;
         next_s.busy_inj = 1'b0;
      end

      // Software writes come last so that a set beats a hardware clear.
      if (wr_ctl) begin
         if (bm[ASC_BIT_REG_GO] & wb_dat_in[ASC_BIT_REG_GO]) begin
            next_s.soft_go = 1'b1;
         end
         if (bm[ASC_BIT_INJ_GO]) begin
            next_s.inj_go = wb_dat_in[ASC_BIT_INJ_GO]; // RQ2
         end
         next_s.reg_ext_en = merged[ASC_BIT_REG_EXT_EN];
         next_s.reg_src = merged[ASC_POS_REG_SRC +: 3];
         next_s.inj_ext_en = merged[ASC_BIT_INJ_EXT_EN];
         next_s.inj_src = merged[ASC_POS_INJ_SRC +: 3];
         next_s.align = merged[ASC_BIT_ALIGN];
         next_s.dma_en = merged[ASC_BIT_DMA];
         next_s.repeat_on = merged[ASC_BIT_REPEAT];
         next_s.power = merged[ASC_BIT_POWER]; // RQ11
         if (!merged[ASC_BIT_POWER]) begin
            next_s.busy_reg = 1'b0; // RQ13
            next_s.busy_inj = 1'b0;
            next_s.reg_start = 1'b0;
            next_s.inj_start = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s <= '0; // RQ17
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_dat_out = s.rdata;
   assign wb_ack_out = s.ack;
   assign core_power_out = s.power;
   assign reg_start_out = s.reg_start;
   assign inj_start_out = s.inj_start;
   assign result_out = s.result;
   assign result_valid_out = s.result_valid;
   assign dma_req_out = s.dma_req;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   logic go_write;
   assign go_write = wr_ctl & bm[ASC_BIT_REG_GO] & wb_dat_in[ASC_BIT_REG_GO];
   // A power-down write in the same cycle cancels the start, so it is left out here.
   a_soft_go_clear: assert property ( // RQ1
      fire_reg && !go_write && (!wr_ctl || merged[ASC_BIT_POWER])
      |=> reg_start_out && !s.soft_go)
      else $error("regular soft start not cleared at conversion start");
   a_inj_go_clear: assert property ( // RQ2
      fire_inj && !wr_ctl |=> inj_start_out && !s.inj_go)
      else $error("injected soft start not cleared at conversion start");
   a_reg_ext_gate: assert property ( // RQ3
      !s.reg_ext_en && !kick && !(core_done_in && s.busy_reg) |=> !reg_start_out)
      else $error("regular start without enable");
   a_reg_src_pick: assert property ( // RQ4
      idle && s.reg_ext_en && s.reg_src == 3'h6 && external_line11_in && !inj_trig
      && !wr_ctl |=> reg_start_out)
      else $error("selected regular event did not start");
   a_inj_ext_gate: assert property ( // RQ5
      !s.inj_ext_en |=> !inj_start_out)
      else $error("injected start without enable");
   a_inj_src_pick: assert property ( // RQ6
      idle && s.inj_ext_en && s.inj_src == 3'h0 && tim1_cc3_in && !wr_ctl
      |=> inj_start_out ##1 !inj_start_out)
      else $error("selected injected event did not start once");
   a_left_align: assert property ( // RQ7
      core_done_in && s.busy_reg && s.align
      |=> result_out == {$past(core_raw_in), 4'h0} && result_valid_out)
      else $error("left justified result wrong");
   a_inj_right: assert property ( // RQ8
      core_done_in && s.busy_inj |=> result_out[15:12] == 4'h0)
      else $error("injected result not right justified");
   a_dma_gate: assert property ( // RQ9
      dma_req_out |-> $past(s.dma_en) && $past(core_done_in))
      else $error("memory request without enable or result");
   a_repeat_run: assert property ( // RQ10
      core_done_in && s.busy_reg && s.repeat_on && !wr_ctl |=> reg_start_out && s.busy_reg)
      else $error("repeat mode did not restart");
   a_wake_only: assert property ( // RQ11
      wr_ctl && !s.power && merged[ASC_BIT_POWER]
      |=> core_power_out && !reg_start_out && !inj_start_out)
      else $error("wake write started a conversion");
   a_kick_start: assert property ( // RQ12
      kick && idle && !inj_trig |=> reg_start_out ##1 s.busy_reg)
      else $error("power rewrite did not start conversion");
   a_power_off: assert property ( // RQ13
      wr_ctl && !merged[ASC_BIT_POWER]
      |=> !core_power_out && !s.busy_reg && !s.busy_inj && !reg_start_out)
      else $error("power down did not stop activity");
   a_kick_change: assert property ( // RQ14
      wr_ctl && s.power && merged[ASC_BIT_POWER] && !s.reg_ext_en && !s.inj_ext_en
      && !(core_done_in && s.busy_reg) && merged[ASC_BIT_REPEAT] != s.repeat_on
      |=> !reg_start_out)
      else $error("conversion started although another bit changed");
   a_one_start: assert property ( // RQ16
      reg_start_out && !(s.busy_reg && s.repeat_on) |-> !$past(reg_start_out))
      else $error("one event started two conversions");
   a_reserved_zero: assert property ( // RQ17
      wb_ack_out |-> (wb_adr_in != ASC_OFS_CTL) || ((wb_dat_out & ~ASC_CTL_WMASK) == 32'h0))
      else $error("reserved control bits read nonzero");
endmodule

/* File: verification/asc_far_model.sv */
// Trigger event sources and a converter core model facing the control block.
// Assumes the bench asks for one event at a time, just after a rising clk_in edge.
`timescale 1ns/100ps
module asc_far_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Bench commands
   input wire logic fire_in,
   input wire logic grp_in,
   input wire logic [2:0] code_in,
   input wire logic [3:0] lat_in,
   input wire logic [11:0] raw_in,
   // Control block side
   input wire logic start_in,
   output logic [6:0] reg_ev_out,
   output logic [6:0] inj_ev_out,
   output logic done_out,
   output logic [11:0] raw_out
);
   logic [3:0] cnt;
   // The raw bus toggles outside done so that a stale value is never mistaken for data.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_ev_out <= 7'h00;
         inj_ev_out <= 7'h00;
         cnt <= 4'h0;
         done_out <= 1'b0;
         raw_out <= 12'h000;
      end else begin
         reg_ev_out <= (fire_in && !grp_in) ? 7'h01 << code_in : 7'h00;
         inj_ev_out <= (fire_in && grp_in) ? 7'h01 << code_in : 7'h00;
         done_out <= (cnt == 4'h1);
         raw_out <= (cnt == 4'h1) ? raw_in : ~raw_out;
         if (start_in) cnt <= lat_in;
         else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      end
   end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the converter start and trigger control block.
// Assumes the far-side model in asc_far_model.sv and the design package.
`timescale 1ns/100ps
module testbench;
   import asc_pkg::*;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0, grp = 1'b0;
   logic [3:0] sel = 4'h0, adr = 4'h0, lat = 4'h3;
   logic [31:0] wdat = 32'h0, rdat, q, c;
   logic [2:0] code = 3'h0;
   logic [11:0] raw = 12'h000, craw;
   logic [6:0] rev, iev;
   logic ack, done, pwr, rs, is, val, dma;
   logic [15:0] res;
   int miscompares = 0, n_compared = 0, cycles = 0, n_rs = 0, n_is = 0, n_dma = 0;
   int e_rs = 0, e_is = 0, e_dma = 0;
   always #10 clk_in = ~clk_in;
   asc_ctrl asc_ctrl_inst (.clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_sel_in(sel), .wb_adr_in(adr), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .tim1_timer_trigger_out_in(rev[0]),
      .tim1_cc1_in(rev[1]), .tim1_cc2_in(rev[2]), .tim2_timer_trigger_out_in(rev[3]),
      .tim2_cc1_in(rev[4]), .tim3_cc1_in(rev[5]), .external_line11_in(rev[6]),
      .tim1_cc3_in(iev[0]), .tim1_cc4_in(iev[1]), .tim2_cc3_in(iev[2]), .tim2_cc4_in(iev[3]),
      .tim2_cc2_in(iev[4]), .tim3_cc2_in(iev[5]), .external_line15_in(iev[6]),
      .core_done_in(done), .core_raw_in(craw), .core_power_out(pwr), .reg_start_out(rs),
      .inj_start_out(is), .result_out(res), .result_valid_out(val), .dma_req_out(dma));
   asc_far_model asc_far_model_inst (.clk_in(clk_in), .resetn_in(resetn_in), .fire_in(fire),
      .grp_in(grp), .code_in(code), .lat_in(lat), .raw_in(raw), .start_in(rs | is),
      .reg_ev_out(rev), .inj_ev_out(iev), .done_out(done), .raw_out(craw));
   task automatic summarize();
      if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Counting high cycles, not edges, so a start pulse that stands too long shows up.
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      n_rs <= n_rs + int'(rs === 1'b1);
      n_is <= n_is + int'(is === 1'b1);
      n_dma <= n_dma + int'(dma === 1'b1);
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      wdat <= d;
      @(posedge clk_in);
      while (ack !== 1'b1) @(posedge clk_in);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
      repeat (12) @(posedge clk_in);
   endtask
   task automatic ev(input logic g, input logic [2:0] k);
      @(posedge clk_in);
      fire <= 1'b1;
      grp <= g;
      code <= k;
      @(posedge clk_in);
      fire <= 1'b0;
      repeat (12) @(posedge clk_in);
   endtask
   task automatic cnts();
      chk(n_rs, e_rs);
      chk(n_is, e_is);
      chk(n_dma, e_dma);
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      chk({31'h0, pwr}, 32'h0);
      rd(ASC_OFS_CTL, ASC_CTL_RESET);
      wr(ASC_OFS_CTL, 32'hffbffffe);
      rd(ASC_OFS_CTL, 32'h003ef902);
      wr(ASC_OFS_CTL, 32'h0);
      rd(ASC_OFS_CTL, 32'h0);
      wr(ASC_OFS_STATUS, 32'hffffffff);
      rd(4'hc, 32'h0);
      rd(ASC_OFS_STATUS, 32'h0);
      raw <= 12'h5a3;
      wr(ASC_OFS_CTL, 32'h1);
      chk({31'h0, pwr}, 32'h1);
      cnts();
      wr(ASC_OFS_CTL, 32'h1);
      e_rs++;
      cnts();
      chk({16'h0, res}, {20'h0, raw});
      chk({31'h0, val}, 32'h1);
      rd(ASC_OFS_STATUS, 32'h9);
      rd(ASC_OFS_RESULT, {20'h0, raw});
      rd(ASC_OFS_STATUS, 32'h1);
      chk({31'h0, val}, 32'h0);
      wr(ASC_OFS_CTL, 32'h801);
      // Only the repeat bit changes here, so the power rewrite must not start anything.
      wr(ASC_OFS_CTL, 32'h803);
      cnts();
      wr(ASC_OFS_CTL, 32'h000c0801);
      ev(1'b0, 3'h6);
      cnts();
      for (int k = 0; k < 7; k++) begin
         c = 32'h00100801 | (k << 17) | ((k & 1) << 8);
         raw <= 12'h100 + 12'(k);
         lat <= 4'(k + 1);
         wr(ASC_OFS_CTL, c);
         ev(1'b0, 3'((k + 1) % 7));
         cnts();
         ev(1'b0, 3'(k));
         e_rs++;
         e_dma += k & 1;
         cnts();
         chk({16'h0, res}, {16'h0, raw, 4'h0});
         rd(ASC_OFS_RESULT, {16'h0, raw, 4'h0});
      end
      wr(ASC_OFS_CTL, 32'h005e0801);
      e_rs++;
      cnts();
      rd(ASC_OFS_CTL, 32'h001e0801);
      wr(ASC_OFS_CTL, 32'h6901);
      ev(1'b1, 3'h6);
      cnts();
      for (int k = 0; k < 8; k++) begin
         c = 32'h8901 | (k << 12) | (k == 7 ? 32'h00200000 : 32'h0);
         raw <= 12'hc30 + 12'(k);
         wr(ASC_OFS_CTL, c);
         if (k < 7) begin
            ev(1'b1, 3'((k + 1) % 7));
            cnts();
            ev(1'b1, 3'(k));
         end
         e_is++;
         cnts();
         chk({16'h0, res}, {20'h0, raw});
         rd(ASC_OFS_RESULT, {20'h0, raw});
      end
      rd(ASC_OFS_CTL, 32'h0000f901);
      lat <= 4'h1;
      // Injected external trigger is kept off while the regular group runs on its own.
      wr(ASC_OFS_CTL, 32'h001d0003);
      ev(1'b0, 3'h6);
      chk(32'(n_rs - e_rs > 2), 32'h1);
      wr(ASC_OFS_CTL, 32'h001d0001);
      e_rs = n_rs;
      repeat (12) @(posedge clk_in);
      cnts();
      wr(ASC_OFS_CTL, 32'h001c0000);
      wb(1'b0, ASC_OFS_RESULT, 32'h0);
      rd(ASC_OFS_STATUS, 32'h0);
      ev(1'b0, 3'h6);
      cnts();
      chk({31'h0, pwr}, 32'h0);
      summarize();
   end
endmodule
